// >>> core/dlc_pkg.sv
// Purpose: constants and types shared by the duty/logic counter
// Assumes: one 125 MHz clock, AXI4-Lite register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package dlc_pkg;
    localparam int unsigned  AW           = 4;        // axi address width
    localparam int unsigned  DW           = 32;       // data width
    localparam logic [3:0]   OFS_CTRL     = 4'h0;     // mode field
    localparam logic [3:0]   OFS_INCR     = 4'h4;     // increment value
    localparam logic [3:0]   OFS_ACCUM    = 4'h8;     // phase accumulator
    localparam logic [3:0]   OFS_STATUS   = 4'hC;     // pins and carry
    localparam int unsigned  MODE_LSB     = 0;        // mode field position
    localparam int unsigned  MODE_W       = 5;        // mode field width
    localparam logic [31:0]  RST_WORD     = 32'h0000_0000; // reset value
    localparam logic [1:0]   RESP_OKAY    = 2'h0;     // axi okay
    localparam logic [1:0]   RESP_DECERR  = 2'h3;     // unmapped address
    localparam logic [4:0]   MODE_OFF     = 5'h00;    // counter off
    localparam logic [4:0]   MODE_DUTY_SE = 5'h06;    // duty single ended
    localparam logic [4:0]   MODE_DUTY_DF = 5'h07;    // duty differential
    localparam logic [4:0]   MODE_NEVER   = 5'h10;    // logic never
    localparam logic [4:0]   MODE_ALWAYS  = 5'h1F;    // logic always
    typedef logic [4:0] dlc_mode_t;                   // mode code type
endpackage

// >>> core/dlc_regs_if.sv
// Purpose: carrier between the counter core and the bus slave
// Assumes: single clock domain
// Notes:   slave writes controls, core returns state
`timescale 1ns/1ps
interface dlc_regs_if;
    logic [4:0]  mode;       // selected mode code
    logic [31:0] incr;       // increment value
    logic        acc_we;     // software accumulator write strobe
    logic [31:0] acc_wdata;  // software accumulator value
    logic [31:0] accum;      // accumulator state
    logic        carry;      // duty carry registered from the last cycle
    logic [1:0]  pins_q;     // registered pin levels
    modport core (input mode, incr, acc_we, acc_wdata,
                  output accum, carry, pins_q);
    modport bus  (output mode, incr, acc_we, acc_wdata,
                  input accum, carry, pins_q);
endinterface

// >>> core/dlc_core.sv
// Purpose: phase accumulator with duty-cycle and logic modes
// Assumes: pins synchronous to MCLK
// Notes:   instantiated by dlc_top
`timescale 1ns/1ps
module dlc_core
    import dlc_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  first_pin_in,
    input  wire logic  second_pin_in,
    dlc_regs_if.core   rif,
    output logic       first_pin_out,
    output logic       second_pin_out,
    output logic       first_pin_oe,
    output logic       second_pin_oe
);
    // logic equation of one mode over registered pins
    function automatic logic eq_true(input logic [4:0] m,
                                     input logic a, input logic b);
        // truth table index {b,a}: bit1 a1b0, bit2 a0b1
        logic [3:0] tt;
        tt = m[3:0];                 // see RULE7 RULE8 RULE11
        return tt[{b, a}];           // see RULE12 RULE13 RULE14
    endfunction

    logic [31:0] accum_r;        // phase accumulator
    logic [1:0]  pins_r;         // previous-cycle pins
    logic        out_r;          // first pin output flop
    logic        dout_r;         // second pin output flop
    logic [32:0] sum;            // 33-bit sum with carry
    logic        is_duty;        // duty modes active
    logic        is_logic;       // logic modes active
    logic        add_en;         // accumulate this cycle

    // wrapping add, carry from bit 32
    assign sum      = {1'b0, accum_r} + {1'b0, rif.incr};   // see RULE16
    assign is_duty  = (rif.mode == MODE_DUTY_SE) ||
                      (rif.mode == MODE_DUTY_DF);           // see RULE1
    assign is_logic = rif.mode[4];                          // see RULE6
    // code bit3..0 is the truth table: 0000 never, 1111 always
    assign add_en   = is_duty ||
                      (is_logic &&
                       eq_true(rif.mode, pins_r[1], pins_r[0])); // see RULE10

    // pins registered a cycle before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_r <= 2'h0;
        end else begin
            pins_r <= {first_pin_in, second_pin_in}; // see RULE9
        end
    end

    // accumulator update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accum_r <= RST_WORD;
        end else if (rif.acc_we) begin
            accum_r <= rif.acc_wdata;     // software write wins
        end else if (add_en) begin
            accum_r <= sum[31:0];         // see RULE6
        end
    end

    // carry drives pins in duty modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r  <= 1'b0;
            dout_r <= 1'b0;
        end else begin
            out_r  <= is_duty & sum[32]; // see RULE2 RULE3 RULE4 RULE5
            dout_r <= (rif.mode == MODE_DUTY_DF) & ~sum[32]; // see RULE15
        end
    end

    logic oe_a_r;                  // first pin drive enable
    logic oe_b_r;                  // second pin drive enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_a_r <= 1'b0;
            oe_b_r <= 1'b0;
        end else begin
            oe_a_r <= is_duty;
            oe_b_r <= (rif.mode == MODE_DUTY_DF);
        end
    end

    assign first_pin_out  = out_r;
    assign second_pin_out = dout_r;
    assign first_pin_oe   = oe_a_r;
    assign second_pin_oe  = oe_b_r;
    assign rif.accum      = accum_r;
    assign rif.carry      = out_r;
    assign rif.pins_q     = pins_r;

    // carry output matches a wrap of the accumulator
    a_duty_carry: assert property (@(posedge clk) disable iff (!rst_n) // see RULE2
        (is_duty && !rif.acc_we) |=> (out_r == (accum_r < $past(accum_r))))
        else $error("duty output does not follow wrap");
    // complement on second pin
    a_diff_compl: assert property (@(posedge clk) disable iff (!rst_n) // see RULE15
        (rif.mode == MODE_DUTY_DF) |=> (dout_r == !out_r))
        else $error("differential pin not complement");
    // never mode holds the accumulator
    a_never_hold: assert property (@(posedge clk) disable iff (!rst_n) // see RULE7
        (rif.mode == MODE_NEVER && !rif.acc_we) |=> $stable(accum_r))
        else $error("never mode changed accumulator");
    // always mode adds every cycle
    a_always_add: assert property (@(posedge clk) disable iff (!rst_n) // see RULE8
        (rif.mode == MODE_ALWAYS && !rif.acc_we)
        |=> accum_r == $past(accum_r) + $past(rif.incr))
        else $error("always mode missed an add");
    // both-low mode uses previous pins
    a_both_low: assert property (@(posedge clk) disable iff (!rst_n) // see RULE10
        (rif.mode == 5'h11 && !rif.acc_we && !pins_r[1] && !pins_r[0])
        |=> accum_r == $past(accum_r) + $past(rif.incr))
        else $error("mode both-low missed an add");
    // both-high mode blocked when a pin low
    a_both_high: assert property (@(posedge clk) disable iff (!rst_n) // see RULE12
        (rif.mode == 5'h18 && !rif.acc_we && !(pins_r[1] && pins_r[0]))
        |=> $stable(accum_r))
        else $error("mode both-high added wrongly");
    // pins reach the pin register one cycle later
    a_pin_delay: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
        1'b1 |=> pins_r == $past({first_pin_in, second_pin_in}))
        else $error("pin register wrong");
    // off state drives nothing
    a_off_quiet: assert property (@(posedge clk) disable iff (!rst_n) // see RULE1
        (!is_duty) [*2] |-> (!out_r && !oe_a_r))
        else $error("pin driven outside duty mode");
endmodule // dlc_core

// >>> core/dlc_top.sv
// Purpose: duty-cycle and logic counter with AXI4-Lite registers
// Assumes: synchronous pins, 125 MHz MCLK, async active-low reset
// Notes:   accumulator readable and writable by software
//
// Behaviour
// RULE1: codes 00110 single, 00111 differential duty
// RULE2: first pin equals addition carry out
// RULE3: increment one gives rare high pulse
// RULE4: high fraction equals increment over 2^32
// RULE5: matches oscillator only at 8000_0000
// RULE6: codes 1xxxx add only when equation true
// RULE7: code 10000 never adds, like off
// RULE8: code 11111 adds every cycle
// RULE9: equations use previous-cycle pin values
// RULE10: 10001 both low, 10010, 10011
// RULE11: 10100, 10101 first low, 10110 differ
// RULE12: 10111, 11000 both high, 11001 equal
// RULE13: 11010, 11011, 11100 second high
// RULE14: 11101, 11110 either pin high
// RULE15: differential mode drives complement on second
// RULE16: 32-bit wrapping add, carry bit 32
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module dlc_top
    import dlc_pkg::*;
(
    input  wire logic                   MCLK,
    input  wire logic                   ARST_N,
    input  wire logic [dlc_pkg::AW-1:0] S_AXI_AWADDR,
    input  wire logic                   S_AXI_AWVALID,
    output logic                        S_AXI_AWREADY,
    input  wire logic [dlc_pkg::DW-1:0] S_AXI_WDATA,
    input  wire logic [3:0]             S_AXI_WSTRB,
    input  wire logic                   S_AXI_WVALID,
    output logic                        S_AXI_WREADY,
    output logic [1:0]                  S_AXI_BRESP,
    output logic                        S_AXI_BVALID,
    input  wire logic                   S_AXI_BREADY,
    input  wire logic [dlc_pkg::AW-1:0] S_AXI_ARADDR,
    input  wire logic                   S_AXI_ARVALID,
    output logic                        S_AXI_ARREADY,
    output logic [dlc_pkg::DW-1:0]      S_AXI_RDATA,
    output logic [1:0]                  S_AXI_RRESP,
    output logic                        S_AXI_RVALID,
    input  wire logic                   S_AXI_RREADY,
    input  wire logic                   FIRST_PIN_IN,
    output logic                        FIRST_PIN_OUT,
    output logic                        FIRST_PIN_OE,
    input  wire logic                   SECOND_PIN_IN,
    output logic                        SECOND_PIN_OUT,
    output logic                        SECOND_PIN_OE
);
    import dlc_pkg::*;

    dlc_regs_if rif ();            // core carrier

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [4:0]  mode_r;           // mode register
    logic [31:0] incr_r;           // increment register
    logic        aw_r;             // address held
    logic        w_r;              // data held
    logic [3:0]  awaddr_r;         // captured write address
    logic [31:0] wdata_r;          // captured write data
    logic [3:0]  wstrb_r;          // captured strobes
    logic        bvalid_r;         // write response pending
    logic [1:0]  bresp_r;          // write response code
    logic        rvalid_r;         // read data pending
    logic [31:0] rdata_r;          // read data
    logic [1:0]  rresp_r;          // read response code
    logic        do_wr;            // both halves present
    logic        wr_ok;            // mapped write address
    logic [31:0] rd_word;          // decoded read word
    logic        rd_ok;            // mapped read address
    logic        rd_take;          // read address accepted
    logic [31:0] ctrl_wr;          // merged control word

    // handshakes: one write and one read at a time
    assign S_AXI_AWREADY = !aw_r && !bvalid_r;
    assign S_AXI_WREADY  = !w_r && !bvalid_r;
    assign S_AXI_ARREADY = !rvalid_r;
    assign rd_take       = S_AXI_ARVALID && !rvalid_r;
    assign do_wr         = aw_r && w_r && !bvalid_r;
    assign wr_ok         = (awaddr_r == OFS_CTRL) ||
                           (awaddr_r == OFS_INCR) ||
                           (awaddr_r == OFS_ACCUM);

    // read decode, status bits: carry, first, second
    assign rd_ok   = (S_AXI_ARADDR == OFS_CTRL)  ||
                     (S_AXI_ARADDR == OFS_INCR)  ||
                     (S_AXI_ARADDR == OFS_ACCUM) ||
                     (S_AXI_ARADDR == OFS_STATUS);
    assign rd_word = (S_AXI_ARADDR == OFS_CTRL)  ? {27'h0, mode_r} :
                     (S_AXI_ARADDR == OFS_INCR)  ? incr_r :
                     (S_AXI_ARADDR == OFS_ACCUM) ? rif.accum :
                     (S_AXI_ARADDR == OFS_STATUS) ?
                         {29'h0, rif.carry, rif.pins_q} : 32'h0;

    // write channel capture and response
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_r     <= 1'b0;
            w_r      <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r  <= RST_WORD;
            wstrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_r     <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_r     <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end
            if (do_wr) begin
                aw_r     <= 1'b0;
                w_r      <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_ok ? RESP_OKAY : RESP_DECERR;
            end else if (bvalid_r && S_AXI_BREADY) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // control registers written by software
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_r <= MODE_OFF;
            incr_r <= RST_WORD;
        end else if (do_wr && awaddr_r == OFS_CTRL) begin
            mode_r <= ctrl_wr[MODE_LSB +: MODE_W];
        end else if (do_wr && awaddr_r == OFS_INCR) begin
            incr_r <= merge(incr_r, wdata_r, wstrb_r);
        end
    end

    // read channel
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rvalid_r <= 1'b0;
            rdata_r  <= RST_WORD;
            rresp_r  <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_ok ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid_r && S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    assign rif.mode      = mode_r;
    assign rif.incr      = incr_r;
    assign rif.acc_we    = do_wr && (awaddr_r == OFS_ACCUM);
    assign rif.acc_wdata = merge(rif.accum, wdata_r, wstrb_r);
    assign ctrl_wr       = merge({27'h0, mode_r}, wdata_r, wstrb_r);

    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP  = bresp_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA  = rdata_r;
    assign S_AXI_RRESP  = rresp_r;

    // duty and logic engine; rules 3..5 follow from the carry add
    dlc_core u_core (
        .clk            (MCLK),
        .rst_n          (ARST_N),
        .first_pin_in   (FIRST_PIN_IN),
        .second_pin_in  (SECOND_PIN_IN),
        .rif            (rif),
        .first_pin_out  (FIRST_PIN_OUT),
        .second_pin_out (SECOND_PIN_OUT),
        .first_pin_oe   (FIRST_PIN_OE),
        .second_pin_oe  (SECOND_PIN_OE)
    );

    // a write is answered one cycle after both halves held
    a_wr_answer: assert property (@(posedge MCLK) disable iff (!ARST_N)
        do_wr |=> bvalid_r)
        else $error("write not answered");
    // mode register follows a control write
    a_mode_write: assert property (@(posedge MCLK) disable iff (!ARST_N) // see RULE6
        (do_wr && awaddr_r == OFS_CTRL && wstrb_r[0])
        |=> mode_r == $past(wdata_r[4:0]))
        else $error("mode write lost");
endmodule // dlc_top

// >>> bench/dlc_pin_model.sv
// Purpose: pin-side partner for the duty/logic counter
// Assumes: plain push-pull pins, no pull resistors
// Notes:   an enabled design driver wins, else the bench level shows
`timescale 1ns/1ps
module dlc_pin_model (
    input  wire logic drv_a,    // bench level for first pin
    input  wire logic drv_b,    // bench level for second pin
    input  wire logic out_a,    // design level on first pin
    input  wire logic oe_a,     // design drives first pin
    input  wire logic out_b,    // design level on second pin
    input  wire logic oe_b,     // design drives second pin
    output logic      in_a,     // resolved first pin level
    output logic      in_b      // resolved second pin level
);
    // resolve each wire from the design's enable alone
    assign in_a = oe_a ? out_a : drv_a;
    assign in_b = oe_b ? out_b : drv_b;
endmodule // dlc_pin_model

// >>> bench/testbench.sv
// Purpose: self-checking bench for the duty/logic counter
// Assumes: AXI4-Lite master in the bench, pin partner model
// Notes:   logic modes are judged against an always-add reference run
`timescale 1ns/1ps
module testbench;
    import dlc_pkg::*;
    logic        mclk, arst_n;                 // clock and reset
    logic [3:0]  aw_addr, ar_addr, w_strb;     // bus address, strobes
    logic [31:0] w_data, rdata;                // bus data
    logic        aw_valid, w_valid, b_ready;   // write channel drive
    logic        ar_valid, r_ready;            // read channel drive
    logic        awready, wready, bvalid;      // write channel answer
    logic        arready, rvalid;              // read channel answer
    logic [1:0]  bresp, rresp;                 // response codes
    logic [1:0]  resp_seen;                    // last response taken
    logic        drv_a, drv_b, in_a, in_b;     // pin levels
    logic        out_a, oe_a, out_b, oe_b;     // design pin drive
    logic        prev_a, prev_oe;              // last cycle's drive
    int          mismatches, n_tests, cycles;  // bookkeeping
    int          c_oe1, c_oe2, c_hi, c_dup, c_bad; // pin statistics
    // accumulate masks per logic mode, bit index {first,second}
    localparam logic [3:0] MASK [16] = '{4'h0, 4'h1, 4'h4, 4'h5,
        4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC, 4'hD, 4'hA, 4'hB,
        4'hE, 4'hF};

    // free-running 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    dlc_top DUT (.MCLK(mclk), .ARST_N(arst_n), .S_AXI_AWADDR(aw_addr),
        .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb),
        .S_AXI_WVALID(w_valid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
        .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(r_ready),
        .FIRST_PIN_IN(in_a), .FIRST_PIN_OUT(out_a), .FIRST_PIN_OE(oe_a),
        .SECOND_PIN_IN(in_b), .SECOND_PIN_OUT(out_b),
        .SECOND_PIN_OE(oe_b));

    dlc_pin_model pins (.drv_a(drv_a), .drv_b(drv_b), .out_a(out_a),
        .oe_a(oe_a), .out_b(out_b), .oe_b(oe_b), .in_a(in_a),
        .in_b(in_b));

    // pin statistics and the hang limit
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        c_oe1 <= c_oe1 + int'(oe_a === 1'b1);
        c_oe2 <= c_oe2 + int'(oe_b === 1'b1);
        c_hi <= c_hi + int'(oe_a === 1'b1 && out_a === 1'b1);
        c_dup <= c_dup + int'(oe_a && prev_oe && out_a === prev_a);
        c_bad <= c_bad + int'(oe_b === 1'b1 && out_b !== ~out_a);
        prev_a <= out_a;
        prev_oe <= oe_a;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    // compare and count
    task automatic chk(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // one write: address and data offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        aw_addr <= a;
        w_data <= d;
        w_strb <= s;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do begin
            @(posedge mclk);
            if (aw_valid && awready) aw_valid <= 1'b0;
            if (w_valid && wready) w_valid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp_seen = bresp;       // taken at the answering edge
    endtask

    // one read, data taken at the answering edge
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do begin
            @(posedge mclk);
            if (ar_valid && arready) ar_valid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        resp_seen = rresp;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
                          input string what);
        logic [31:0] v;
        rd(a, v);
        chk(v, e, what);
    endtask

    // reset values, byte strobes, read-only status
    task automatic t_regs();
        rd_chk(OFS_CTRL, RST_WORD, "ctrl reset");
        rd_chk(OFS_INCR, RST_WORD, "incr reset");
        rd_chk(OFS_ACCUM, RST_WORD, "accum reset");
        wr(OFS_INCR, 32'hFFFF_FFFF);
        wr(OFS_INCR, 32'h0000_00AB, 4'h1);
        chk(32'(resp_seen), 32'(RESP_OKAY), "write resp");
        rd_chk(OFS_INCR, 32'hFFFF_FFAB, "incr strobe");
        chk(32'(resp_seen), 32'(RESP_OKAY), "read resp");
        drv_a <= 1'b1;
        repeat (3) @(posedge mclk);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        chk(32'(resp_seen), 32'(RESP_DECERR), "read-only write resp");
        rd_chk(OFS_STATUS, 32'h0000_0002, "status pins");
        rd_chk(4'h2, 32'h0, "unmapped read");
        chk(32'(resp_seen), 32'(RESP_DECERR), "unmapped resp");
        drv_a <= 1'b0;
    endtask

    // run a duty mode for a while, judge carries and accumulator
    task automatic t_duty(input dlc_mode_t m, input logic [31:0] inc, a0);
        int          s1, s2, sh, sd, sb;
        logic [63:0] tot;
        wr(OFS_CTRL, {27'h0, MODE_OFF});
        wr(OFS_ACCUM, a0);
        wr(OFS_INCR, inc);
        s1 = c_oe1;
        s2 = c_oe2;
        sh = c_hi;
        sd = c_dup;
        sb = c_bad;
        wr(OFS_CTRL, {27'h0, m});
        repeat (300) @(posedge mclk);
        wr(OFS_CTRL, {27'h0, MODE_OFF});
        repeat (3) @(posedge mclk);
        s1 = c_oe1 - s1;
        tot = 64'(a0) + 64'(s1) * 64'(inc);
        chk(32'(s1), 32'h0000_012F, "first enable");
        chk(32'(c_hi - sh), tot[63:32], "carries");
        rd_chk(OFS_ACCUM, tot[31:0], "accum wrap");
        chk(32'(c_oe2 - s2), (m == MODE_DUTY_DF) ? 32'(s1) : 32'h0,
            "second enable");
        chk(32'(c_bad - sb), 32'h0, "complement");
        if (inc == 32'h8000_0000) chk(32'(c_dup - sd), 32'h0, "toggle");
    endtask

    // one logic-mode window with pins held
    task automatic run_one(input int m, ab, output logic [31:0] v);
        drv_a <= ab[1];
        drv_b <= ab[0];
        wr(OFS_ACCUM, 32'h0);
        wr(OFS_CTRL, 32'(m));
        wr(OFS_CTRL, 32'h0);
        rd(OFS_ACCUM, v);
    endtask

    // every logic mode against every pin pair
    task automatic t_logic();
        logic [31:0] nref, v, e;
        wr(OFS_INCR, 32'h1);
        run_one(31, 0, nref);
        chk(nref, 32'h0000_0003, "always adds");
        for (int i = 0; i < 64; i++) begin
            run_one(16 + i / 4, i % 4, v);
            e = MASK[i / 4][i % 4] ? nref : 32'h0;
            chk(v, e, "equation");
            chk(v, e, "equation");
        end
    endtask

    // a pulse of k cycles on the first pin adds k times
    task automatic t_pulse(input int k);
        drv_a <= 1'b0;           // first pin low before counting
        wr(OFS_ACCUM, 32'h0);
        wr(OFS_CTRL, 32'h0000_001A);
        drv_a <= 1'b1;
        repeat (k) @(posedge mclk);
        drv_a <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_chk(OFS_ACCUM, 32'(k), "pulse");
        wr(OFS_CTRL, 32'h0);
    endtask

    task automatic summarize();
        if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence
    initial begin
        {arst_n, aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
        {aw_addr, ar_addr, w_strb, w_data, drv_a, drv_b} = '0;
        {mismatches, n_tests, cycles, c_oe1, c_oe2} = '0;
        {c_hi, c_dup, c_bad, prev_a, prev_oe} = '0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_duty(MODE_DUTY_SE, 32'h8000_0000, 32'h0);
        t_duty(MODE_DUTY_DF, 32'h5555_5556, 32'h0);
        t_duty(MODE_DUTY_SE, 32'h1, 32'hFFFF_FFF0);
        t_duty(MODE_DUTY_DF, 32'hFFFF_FFFF, 32'h5);
        t_logic();
        t_pulse(1);
        t_pulse(3);
        summarize();
    end
endmodule // testbench
